// ---- dtl_debounce.sv ----
`timescale 1ns/10ps
module dtl_debounce
  import dtl_pkg::*;
#(
  parameter int STABLE_CYC = DEBOUNCE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      level_o
);
  initial if (STABLE_CYC < 1) $error("bad debounce count");
  logic       s1_r;
  logic       s2_r;
  logic [31:0] cnt_r;
  // two flops before anything looks at the pin
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_r   <= 32'h0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      if (s2_r == level_o) cnt_r <= 32'h0;
      else if (cnt_r >= 32'(STABLE_CYC - 1)) begin
        level_o <= s2_r;
        cnt_r   <= 32'h0;
      end else cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule

// ---- dtl_out_sel.sv ----
`timescale 1ns/10ps
module dtl_out_sel
  import dtl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic [5:0] sel_i,
  dtl_stat_if.dst   st,
  output logic      contact_o
);
  // codes above 32 read as disabled
  always_ff @(posedge clk_i) begin
    if (!rstn_i) contact_o <= 1'b0;
    else if (ce_i) contact_o <= (sel_i != 6'h00 && sel_i <= FUNC_MAX) ? st.evt[sel_i] : 1'b0;
  end
endmodule

// ---- dtl_pkg.sv ----
package dtl_pkg;
  localparam int          CLK_MHZ        = 250;
  localparam int          DEBOUNCE_US    = 1000;
  localparam int          DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
  localparam int          TRIM_FAST_US   = 20000;
  localparam int          TRIM_FAST_CYC  = TRIM_FAST_US * CLK_MHZ;
  localparam int          TRIM_SLOW_US   = 100000;
  localparam int          TRIM_SLOW_CYC  = TRIM_SLOW_US * CLK_MHZ;
  localparam int          TRIM_FAST_STEPS = 20;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [15:0] CNT_TARGET_MAX = 16'hffdc;
  localparam logic [15:0] FREQ_RST       = 16'h0000;
  localparam int          NUM_IN         = 6;
  localparam int          NUM_OUT        = 4;
  // input function codes
  localparam logic [5:0] IF_RUN  = 6'h01;
  localparam logic [5:0] IF_FWD  = 6'h02;
  localparam logic [5:0] IF_REV  = 6'h03;
  localparam logic [5:0] IF_STOP = 6'h04;
  localparam logic [5:0] IF_DIR  = 6'h05;
  localparam logic [5:0] IF_SPH  = 6'h11;
  localparam logic [5:0] IF_SPM  = 6'h12;
  localparam logic [5:0] IF_SPL  = 6'h13;
  localparam logic [5:0] IF_RMP1 = 6'h17;
  localparam logic [5:0] IF_RMP2 = 6'h18;
  localparam logic [5:0] IF_UP   = 6'h19;
  localparam logic [5:0] IF_DOWN = 6'h1a;
  localparam logic [5:0] IF_CPUL = 6'h1b;
  localparam logic [5:0] IF_CRST = 6'h1c;
  localparam logic [5:0] FUNC_MAX = 6'h20;
  // operation modes
  localparam logic [2:0] OPM_FOUR_SPEED = 3'h1;
  localparam logic [2:0] OPM_RAMP_MAX   = 3'h2;
  localparam logic [1:0] FSRC_PANEL     = 2'h0;
  typedef enum logic [1:0] {TR_IDLE = 2'b00, TR_FAST = 2'b01, TR_SLOW = 2'b11} dtl_trim_type;
endpackage

// ---- dtl_stat_if.sv ----
`timescale 1ns/10ps
// status flags handed to each contact selector
interface dtl_stat_if;
  logic [32:0] evt;
  modport src (output evt);
  modport dst (input evt);
endinterface

// ---- dtl_switches.sv ----
`timescale 1ns/10ps
module dtl_switches (
  input  wire logic       clk_i,
  input  wire logic [5:0] want_i,
  output logic      [5:0] pin_o
);
  logic [5:0] prev_r;
  logic [5:0] chg_r;
  logic [1:0] bnc_r;
  initial begin
    pin_o = 6'h00;
    prev_r = 6'h00;
    chg_r = 6'h00;
    bnc_r = 2'h0;
  end
  // contacts chatter three cycles, kept shorter than the debounce window
  always @(posedge clk_i) begin
    prev_r <= want_i;
    if (want_i != prev_r) begin
      chg_r <= want_i ^ prev_r;
      bnc_r <= 2'h3;
    end else if (bnc_r != 2'h0) begin
      bnc_r <= bnc_r - 2'h1;
    end
    pin_o <= (bnc_r != 2'h0) ? (pin_o ^ chg_r) : want_i;
  end
endmodule

// ---- dtl_top.sv ----
`timescale 1ns/10ps
module dtl_top
  import dtl_pkg::*;
#(
  parameter int DB_CYC    = DEBOUNCE_CYC,
  parameter int FAST_CYC  = TRIM_FAST_CYC,
  parameter int SLOW_CYC  = TRIM_SLOW_CYC,
  parameter int FAST_STEP = TRIM_FAST_STEPS
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [5:0]  input_pin_i,
  input  wire logic [5:0]  input1_func_sel_i,
  input  wire logic [5:0]  input2_func_sel_i,
  input  wire logic [5:0]  input3_func_sel_i,
  input  wire logic [5:0]  input4_func_sel_i,
  input  wire logic [5:0]  input5_func_sel_i,
  input  wire logic [5:0]  input6_func_sel_i,
  input  wire logic [2:0]  operation_mode_sel_i,
  input  wire logic [1:0]  frequency_source_sel_i,
  input  wire logic        trim_retain_sel_i,
  input  wire logic [15:0] main_setpoint_i,
  input  wire logic [15:0] low_preset_freq_i,
  input  wire logic [15:0] mid_preset_freq_i,
  input  wire logic [15:0] high_preset_freq_i,
  input  wire logic [15:0] max_freq_i,
  input  wire logic [15:0] min_freq_i,
  input  wire logic [15:0] trim_step_i,
  input  wire logic [15:0] count_target_i,
  input  wire logic [15:0] intermediate_count_target_i,
  input  wire logic [5:0]  output1_func_sel_i,
  input  wire logic [5:0]  output2_func_sel_i,
  input  wire logic [5:0]  output3_func_sel_i,
  input  wire logic [5:0]  output4_func_sel_i,
  input  wire logic        running_i,
  input  wire logic        fault_i,
  input  wire logic        below_start_i,
  input  wire logic        dc_brake_i,
  input  wire logic        set_reach_i,
  input  wire logic        uniform_one_reach_i,
  input  wire logic        uniform_two_reach_i,
  input  wire logic        accel_i,
  input  wire logic        decel_i,
  input  wire logic [3:0]  alarm_i,
  input  wire logic        step_end_i,
  input  wire logic        cycle_end_i,
  input  wire logic [2:0]  misc_evt_i,
  input  wire logic        drawing_done_i,
  input  wire logic        pid_low_i,
  input  wire logic        pid_high_i,
  input  wire logic [2:0]  spare_evt_i,
  input  wire logic        power_restore_i,
  output logic             run_o,
  output logic             reverse_o,
  output logic [1:0]       ramp_sel_o,
  output logic [15:0]      freq_set_o,
  output logic [15:0]      count_o,
  output logic [3:0]       contact_o
);
  initial if (DB_CYC < 1 || FAST_CYC < 1 || SLOW_CYC < 1 || FAST_STEP < 1)
    $error("bad timing parameter");

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  logic [5:0] in_lvl;
  logic [5:0] func_sel [NUM_IN];
  assign func_sel[0] = input1_func_sel_i;
  assign func_sel[1] = input2_func_sel_i;
  assign func_sel[2] = input3_func_sel_i;
  assign func_sel[3] = input4_func_sel_i;
  assign func_sel[4] = input5_func_sel_i;
  assign func_sel[5] = input6_func_sel_i;

  for (genvar g = 0; g < NUM_IN; g++) begin : g_db
    dtl_debounce #(.STABLE_CYC(DB_CYC)) u_db (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .ce_i    (ce_i),
      .pin_i   (input_pin_i[g]),
      .level_o (in_lvl[g])
    );
  end

  function automatic logic fn_on(input logic [5:0] code, input logic [5:0] lvl,
                                 input logic [5:0] s0, input logic [5:0] s1,
                                 input logic [5:0] s2, input logic [5:0] s3,
                                 input logic [5:0] s4, input logic [5:0] s5);
    fn_on = (lvl[0] && s0 == code) || (lvl[1] && s1 == code) || (lvl[2] && s2 == code) ||
            (lvl[3] && s3 == code) || (lvl[4] && s4 == code) || (lvl[5] && s5 == code);
  endfunction

  logic f_run, f_fwd, f_rev, f_stop, f_dir, f_sph, f_spm, f_spl;
  logic f_r1, f_r2, f_up, f_dn, f_cp, f_crst;
  always_comb begin
    f_run  = fn_on(IF_RUN,  in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_fwd  = fn_on(IF_FWD,  in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_rev  = fn_on(IF_REV,  in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_stop = fn_on(IF_STOP, in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_dir  = fn_on(IF_DIR,  in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_sph  = fn_on(IF_SPH,  in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_spm  = fn_on(IF_SPM,  in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_spl  = fn_on(IF_SPL,  in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_r1   = fn_on(IF_RMP1, in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_r2   = fn_on(IF_RMP2, in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_up   = fn_on(IF_UP,   in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_dn   = fn_on(IF_DOWN, in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_cp   = fn_on(IF_CPUL, in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
    f_crst = fn_on(IF_CRST, in_lvl, func_sel[0], func_sel[1], func_sel[2],
                   func_sel[3], func_sel[4], func_sel[5]);
  end

  // ----------------------------------------------------------------
  // run and direction
  // ----------------------------------------------------------------
  logic fwd_d_r, rev_d_r, run_d_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fwd_d_r <= 1'b0;
      rev_d_r <= 1'b0;
      run_d_r <= 1'b0;
    end else if (ce_i) begin
      fwd_d_r <= f_fwd;
      rev_d_r <= f_rev;
      run_d_r <= f_run;
    end
  end

  // stop wins over a start seen in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      run_o     <= 1'b0;
      reverse_o <= 1'b0;
    end else if (ce_i) begin
      if (f_stop) run_o <= 1'b0;
      else if (f_fwd && !fwd_d_r) begin
        run_o     <= 1'b1;
        reverse_o <= 1'b0;
      end else if (f_rev && !rev_d_r) begin
        run_o     <= 1'b1;
        reverse_o <= 1'b1;
      end else if (f_run) begin
        run_o     <= 1'b1;
        reverse_o <= f_dir;
      end else if (run_d_r) run_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ramp select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) ramp_sel_o <= 2'b00;
    else if (ce_i) begin
      if (operation_mode_sel_i <= OPM_RAMP_MAX) ramp_sel_o <= {f_r2, f_r1};
      else ramp_sel_o <= 2'b00;
    end
  end

  // ----------------------------------------------------------------
  // up/down trim
  // ----------------------------------------------------------------
  dtl_trim_type tr_st_r;
  logic [31:0]  tr_cnt_r;
  logic [7:0]   tr_steps_r;
  logic [15:0]  trim_r;
  logic         trim_act;
  logic         trim_tick;
  logic         up_only, dn_only;
  assign up_only   = f_up && !f_dn;
  assign dn_only   = f_dn && !f_up;
  assign trim_act  = (frequency_source_sel_i == FSRC_PANEL) && (up_only || dn_only);
  assign trim_tick = (tr_st_r == TR_IDLE) ||
                     (tr_st_r == TR_FAST && tr_cnt_r >= 32'(FAST_CYC - 1)) ||
                     (tr_st_r == TR_SLOW && tr_cnt_r >= 32'(SLOW_CYC - 1));

  // fast repeat first, then slower steady repeat
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tr_st_r    <= TR_IDLE;
      tr_cnt_r   <= 32'h0;
      tr_steps_r <= 8'h0;
    end else if (ce_i) begin
      if (!trim_act) begin
        tr_st_r    <= TR_IDLE;
        tr_cnt_r   <= 32'h0;
        tr_steps_r <= 8'h0;
      end else begin
        case (tr_st_r)
          TR_IDLE: tr_st_r <= TR_FAST;
          TR_FAST: if (trim_tick) begin
            tr_cnt_r   <= 32'h0;
            tr_steps_r <= tr_steps_r + 8'h1;
            if (tr_steps_r >= 8'(FAST_STEP - 1)) tr_st_r <= TR_SLOW;
          end else tr_cnt_r <= tr_cnt_r + 32'h1;
          TR_SLOW: if (trim_tick) tr_cnt_r <= 32'h0;
                   else tr_cnt_r <= tr_cnt_r + 32'h1;
          default: tr_st_r <= TR_IDLE;
        endcase
      end
    end
  end

  logic [16:0] up_sum;
  assign up_sum = {1'b0, trim_r} + {1'b0, trim_step_i};
  always_ff @(posedge clk_i) begin
    if (!rstn_i) trim_r <= FREQ_RST;
    else if (ce_i) begin
      if (power_restore_i && !trim_retain_sel_i) trim_r <= main_setpoint_i;
      else if (frequency_source_sel_i != FSRC_PANEL) trim_r <= main_setpoint_i;
      else if (trim_act && trim_tick) begin
        if (up_only)
          trim_r <= (up_sum > {1'b0, max_freq_i}) ? max_freq_i : up_sum[15:0];
        else
          trim_r <= (trim_r < min_freq_i + trim_step_i) ? min_freq_i
                    : trim_r - trim_step_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // setpoint choice
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) freq_set_o <= FREQ_RST;
    else if (ce_i) begin
      if (operation_mode_sel_i == OPM_FOUR_SPEED && run_o) begin
        if (f_sph) freq_set_o <= high_preset_freq_i;
        else if (f_spm) freq_set_o <= mid_preset_freq_i;
        else if (f_spl) freq_set_o <= low_preset_freq_i;
        else freq_set_o <= trim_r;
      end else freq_set_o <= trim_r;
    end
  end

  // ----------------------------------------------------------------
  // pulse counter
  // ----------------------------------------------------------------
  logic        cp_d_r;
  logic        cnt_hit;
  logic [15:0] tgt;
  // targets above the range clip to the top value
  assign tgt     = (count_target_i > CNT_TARGET_MAX) ? CNT_TARGET_MAX : count_target_i;
  assign cnt_hit = (count_o == tgt);
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cp_d_r  <= 1'b0;
      count_o <= 16'h0000;
    end else if (ce_i) begin
      cp_d_r <= f_cp;
      if (f_crst) count_o <= 16'h0000;
      else if (f_cp && !cp_d_r && !cnt_hit && count_o != CNT_MAX)
        count_o <= count_o + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // output contacts
  // ----------------------------------------------------------------
  logic draw_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) draw_r <= 1'b0;
    else if (ce_i) begin
      if (drawing_done_i) draw_r <= 1'b1;
      else if (!running_i) draw_r <= 1'b0;
    end
  end

  dtl_stat_if st_if ();
  // codes 21..26 have no event behind them and read as off
  assign st_if.evt = {spare_evt_i, pid_high_i, pid_low_i, draw_r,
                      6'h00, misc_evt_i,
                      (count_o >= intermediate_count_target_i), cnt_hit,
                      cycle_end_i, step_end_i, alarm_i,
                      decel_i, accel_i, uniform_two_reach_i, uniform_one_reach_i,
                      set_reach_i, dc_brake_i, below_start_i, fault_i,
                      running_i || run_o, 1'b0};

  logic [5:0] osel [NUM_OUT];
  assign osel[0] = output1_func_sel_i;
  assign osel[1] = output2_func_sel_i;
  assign osel[2] = output3_func_sel_i;
  assign osel[3] = output4_func_sel_i;
  for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
    dtl_out_sel u_os (
      .clk_i     (clk_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .sel_i     (osel[o]),
      .st        (st_if.dst),
      .contact_o (contact_o[o])
    );
  end
endmodule

// ---- dtl_top_asserts.sv ----
`timescale 1ns/10ps
module dtl_top_asserts (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        ce_i,
  input wire logic [2:0]  operation_mode_sel_i,
  input wire logic [15:0] count_target_i,
  input wire logic [15:0] intermediate_count_target_i,
  input wire logic [5:0]  output1_func_sel_i,
  input wire logic [5:0]  output2_func_sel_i,
  input wire logic [5:0]  output3_func_sel_i,
  input wire logic [5:0]  output4_func_sel_i,
  input wire logic        fault_i,
  input wire logic [1:0]  ramp_sel_o,
  input wire logic [15:0] count_o,
  input wire logic [3:0]  contact_o
);
  // targets above the top of the range are clipped inside the block
  logic [15:0] tgt_eff;
  assign tgt_eff = (count_target_i > 16'hffdc) ? 16'hffdc : count_target_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_fault_contact: assert property ($past(rstn_i) && $past(ce_i) &&
    $past(output1_func_sel_i) == 6'h02 |-> contact_o[0] == $past(fault_i))
    else $error("fault contact does not follow fault input");
  chk_zero_code_off: assert property ($past(rstn_i) && $past(ce_i) &&
    $past(output1_func_sel_i) == 6'h00 |-> !contact_o[0])
    else $error("contact with code zero is active");
  chk_big_code_off: assert property ($past(rstn_i) && $past(ce_i) &&
    $past(output2_func_sel_i) > 6'h20 |-> !contact_o[1])
    else $error("contact with code above range is active");
  chk_equal_count: assert property ($past(rstn_i) && $past(ce_i) &&
    $past(output3_func_sel_i) == 6'h10 |-> contact_o[2] == ($past(count_o) == $past(tgt_eff)))
    else $error("count reach contact wrong");
  chk_mid_count: assert property ($past(rstn_i) && $past(ce_i) &&
    $past(output4_func_sel_i) == 6'h11 |->
    contact_o[3] == ($past(count_o) >= $past(intermediate_count_target_i)))
    else $error("intermediate count contact wrong");
  chk_count_step: assert property (count_o != $past(count_o) |->
    count_o == 16'h0000 || count_o == $past(count_o) + 16'h0001)
    else $error("count moved by other than one");
  chk_count_hold: assert property (count_o > $past(count_o) |->
    $past(count_o) < $past(tgt_eff))
    else $error("count advanced past target");
  chk_ramp_mode_off: assert property ((ce_i && operation_mode_sel_i > 3'h2)[*2] |->
    ramp_sel_o == 2'h0)
    else $error("ramp select active in excluded mode");

  cover property (contact_o[2]);
  cover property (ramp_sel_o == 2'h3);
  cover property (count_o != 16'h0000 && count_o == tgt_eff);
endmodule

bind dtl_top dtl_top_asserts i_chk (.clk_i, .rstn_i, .ce_i, .operation_mode_sel_i,
  .count_target_i, .intermediate_count_target_i, .output1_func_sel_i, .output2_func_sel_i,
  .output3_func_sel_i, .output4_func_sel_i, .fault_i, .ramp_sel_o, .count_o, .contact_o);

// ---- tb_drive_terminal_logic.sv ----
`timescale 1ns/10ps
module tb_drive_terminal_logic
  import dtl_pkg::*;
;
  localparam int DB = 4;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        retain = 1'b0;
  logic        restore = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic [1:0]  src = 2'h1;
  logic [5:0]  want = 6'h00;
  logic [5:0]  pin;
  logic [5:0]  fs [6] = '{default: 6'h00};
  logic [5:0]  os [4] = '{default: 6'h00};
  logic [32:0] st = 33'h0;
  logic [15:0] main_f = 16'h0064, lo_f = 16'h0, mid_f = 16'h0, hi_f = 16'h0;
  logic [15:0] max_f = 16'hffff, min_f = 16'h0, step = 16'h000a;
  logic [15:0] tgt = 16'h0005, mid_t = 16'h0003;
  logic        run_o, reverse_o;
  logic [1:0]  ramp_sel_o;
  logic [15:0] freq_set_o, count_o;
  logic [3:0]  contact_o;
  int          n_mismatch = 0;
  int          total_checks = 0;
  logic        e;

  always #2 clk_i = ~clk_i;

  dtl_switches i_sw (.clk_i, .want_i(want), .pin_o(pin));

  dtl_top #(.DB_CYC(DB), .FAST_CYC(3), .SLOW_CYC(8), .FAST_STEP(3)) i_dut (
    .clk_i, .rstn_i, .ce_i, .input_pin_i(pin), .input1_func_sel_i(fs[0]),
    .input2_func_sel_i(fs[1]), .input3_func_sel_i(fs[2]), .input4_func_sel_i(fs[3]),
    .input5_func_sel_i(fs[4]), .input6_func_sel_i(fs[5]), .operation_mode_sel_i(mode),
    .frequency_source_sel_i(src), .trim_retain_sel_i(retain), .main_setpoint_i(main_f),
    .low_preset_freq_i(lo_f), .mid_preset_freq_i(mid_f), .high_preset_freq_i(hi_f),
    .max_freq_i(max_f), .min_freq_i(min_f), .trim_step_i(step), .count_target_i(tgt),
    .intermediate_count_target_i(mid_t), .output1_func_sel_i(os[0]),
    .output2_func_sel_i(os[1]), .output3_func_sel_i(os[2]), .output4_func_sel_i(os[3]),
    .running_i(st[1]), .fault_i(st[2]), .below_start_i(st[3]), .dc_brake_i(st[4]),
    .set_reach_i(st[5]), .uniform_one_reach_i(st[6]), .uniform_two_reach_i(st[7]),
    .accel_i(st[8]), .decel_i(st[9]), .alarm_i(st[13:10]), .step_end_i(st[14]),
    .cycle_end_i(st[15]), .misc_evt_i(st[20:18]), .drawing_done_i(st[27]),
    .pid_low_i(st[28]), .pid_high_i(st[29]), .spare_evt_i(st[32:30]),
    .power_restore_i(restore), .run_o, .reverse_o, .ramp_sel_o, .freq_set_o, .count_o,
    .contact_o);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // wait covers chatter, sync flops and the debounce window
  task automatic pins(logic [5:0] v);
    want <= v;
    cyc(DB + 12);
  endtask

  task automatic pulse(int b);
    pins(want | 6'(1 << b));
    pins(want & ~6'(1 << b));
  endtask

  function automatic logic [15:0] speed_exp(logic [2:0] m, logic [2:0] v);
    if (m != OPM_FOUR_SPEED) return main_f;
    return v[0] ? hi_f : v[1] ? mid_f : v[2] ? lo_f : main_f;
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    results();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(99188));
    cyc(16);
    rstn_i <= 1'b1;
    cyc(DB + 4);
    for (int c = 0; c < 35; c++) begin
      st <= 33'({$urandom, $urandom}) & ~(33'h1 << 27);
      os <= '{4{6'(c)}};
      cyc(3);
      e = (c == 0 || c > 32 || (c > 15 && c < 18) || (c > 20 && c < 28)) ? 1'b0 : st[c];
      for (int k = 0; k < 4; k++) chk("contact", 16'(e), 16'(contact_o[k]));
    end
    st <= 33'h0;
    fs <= '{IF_RUN, IF_DIR, 6'h00, 6'h00, 6'h00, 6'h00};
    pins(6'h01);
    chk("run", 16'h1, 16'(run_o));
    chk("reverse", 16'h0, 16'(reverse_o));
    pins(6'h03);
    chk("reverse", 16'h1, 16'(reverse_o));
    pins(6'h00);
    chk("run", 16'h0, 16'(run_o));
    fs <= '{IF_FWD, IF_REV, IF_STOP, 6'h00, 6'h00, 6'h00};
    pulse(0);
    chk("run", 16'h1, 16'(run_o));
    chk("reverse", 16'h0, 16'(reverse_o));
    pulse(1);
    chk("reverse", 16'h1, 16'(reverse_o));
    pulse(2);
    chk("run", 16'h0, 16'(run_o));
    fs <= '{IF_RMP1, IF_RMP2, 6'h00, 6'h00, 6'h00, 6'h00};
    for (int m = 0; m < 6; m += 2) begin
      mode <= 3'(m);
      for (int v = 0; v < 4; v++) begin
        pins(6'(v));
        chk("ramp_sel", (m > 2) ? 16'h0 : 16'(v), 16'(ramp_sel_o));
      end
    end
    fs <= '{IF_RUN, IF_SPH, IF_SPM, IF_SPL, 6'h00, 6'h00};
    {main_f, lo_f, mid_f, hi_f} <= {$urandom, $urandom};
    for (int m = 1; m >= 0; m--) begin
      mode <= 3'(m);
      for (int v = 0; v < 8; v++) begin
        pins({2'h0, 3'(v), 1'b1});
        chk("freq_set", speed_exp(3'(m), 3'(v)), freq_set_o);
      end
    end
    // trim limits chosen so saturation is reached in a few steps
    fs <= '{IF_UP, IF_DOWN, 6'h00, 6'h00, 6'h00, 6'h00};
    {main_f, max_f, min_f} <= {16'h0064, 16'h0096, 16'h0032};
    pins(6'h01);
    chk("freq_set", 16'h0064, freq_set_o);
    pins(6'h00);
    src <= 2'h0;
    pins(6'h01);
    cyc(200);
    chk("freq_set", 16'h0096, freq_set_o);
    pins(6'h02);
    cyc(200);
    chk("freq_set", 16'h0032, freq_set_o);
    pins(6'h03);
    cyc(40);
    chk("freq_set", 16'h0032, freq_set_o);
    for (int r = 0; r < 2; r++) begin
      retain <= 1'(r);
      pins(6'h01);
      cyc(200);
      pins(6'h00);
      restore <= 1'b1;
      cyc(1);
      restore <= 1'b0;
      cyc(3);
      chk("freq_set", r ? 16'h0096 : 16'h0064, freq_set_o);
    end
    fs <= '{IF_CPUL, IF_CRST, 6'h00, 6'h00, 6'h00, 6'h00};
    os <= '{6'h00, 6'h00, 6'h10, 6'h11};
    repeat (3) pulse(0);
    chk("count", 16'h0003, count_o);
    chk("contact", 16'h0002, 16'(contact_o[3:2]));
    repeat (4) pulse(0);
    chk("count", 16'h0005, count_o);
    chk("contact", 16'h0003, 16'(contact_o[3:2]));
    pulse(1);
    chk("count", 16'h0000, count_o);
    pulse(0);
    chk("count", 16'h0001, count_o);
    results();
  end
endmodule
